// ==== hw/slt_checker.v ====
// Receiver-side self-test checker with AHB-Lite register slave.
// Assumes frame and back-channel strobes come from core_clk logic;
// pins and the pixel clock are asynchronous and are synchronised here.
//
// How it works
// - Pin or control bit starts self-test
// - Test clock: pixel clock or 33 MHz oscillator
// - Start sends request over back channel
// - Both in test and locked: result high
// - Errored frame: result low half clock
// - Enable low: stop, hold pass or fail
// - Verdict held until restart, reset, power-down
// - Lock output valid throughout test
// - Enable low returns link to normal
// - Forward errors counted, read at 0x25
// - CRC counted after remote back-channel lock
// - Functional CRC count clears on remote start
// - Test CRC count only during test, retained
// - Back channel runs at 10 Mbps
// - Power-down resets all registers and verdict
`timescale 1ns/1ps
`include "slt_defs.vh"
module slt_checker (
    input  wire                    core_clk,
    input  wire                    resetn,
    // AHB-Lite slave
    input  wire                    hsel,
    input  wire [31:0]             haddr,
    input  wire [1:0]              htrans,
    input  wire                    hwrite,
    input  wire [2:0]              hsize,
    input  wire [31:0]             hwdata,
    input  wire                    hready,
    output wire                    hreadyout,
    output wire                    hresp,
    output reg  [31:0]             hrdata,
    // Pins
    input  wire                    self_test_enable_pin,
    input  wire                    self_test_clock_select_pin,
    input  wire                    power_down_input,
    input  wire                    pixel_clk_pin,
    input  wire                    rx_lock_pin,
    // Recovered link, core_clk domain
    input  wire                    rx_frame_valid,
    input  wire [`SLT_FRAME_W:1]   rx_frame_bits,
    input  wire                    remote_bc_lock,
    input  wire                    remote_self_test,
    input  wire                    bc_frame_valid,
    input  wire                    bc_crc_error,
    // Outputs
    output reg                     bc_self_test_request,
    output wire                    bc_bit_tick,
    output reg                     pass_out,
    output wire                    lock_out,
    output reg                     link_normal
);
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_REQ   = 2'd1;
    localparam [1:0] ST_CHECK = 2'd2;
    localparam [1:0] ST_HOLD  = 2'd3;
    localparam [`SLT_CNT_W-1:0] CNT_MAX = {`SLT_CNT_W{1'b1}};

    function [7:0] word_index;
        input [31:0] addr;
        begin
            word_index = addr[9:2];
        end
    endfunction

    function [`SLT_CNT_W-1:0] sat_inc;
        input [`SLT_CNT_W-1:0] v;
        begin
            sat_inc = (v == CNT_MAX) ? v : v + 1'b1;
        end
    endfunction

    // Pin synchronisers; power-down enters inverted so that the
    // synchroniser's reset level means running, not powered down
    wire [4:0] pins_raw;
    wire [4:0] pins_s;
    assign pins_raw[0] = self_test_enable_pin;
    assign pins_raw[1] = self_test_clock_select_pin;
    assign pins_raw[2] = ~power_down_input;
    assign pins_raw[3] = pixel_clk_pin;
    assign pins_raw[4] = rx_lock_pin;
    slt_sync #(.W(5)) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );
    wire en_pin_s  = pins_s[0];
    wire sel_pin_s = pins_s[1];
    wire pd_s      = pins_s[2];
    wire pclk_s    = pins_s[3];
    wire lock_s    = pins_s[4];

    // Power-down is a synchronous clear of all state
    wire pd_clear = pd_s;

    assign lock_out = lock_s;

    // Registers
    reg  [1:0]            ctrl;
    reg  [1:0]            state;
    reg  [1:0]            next_state;
    reg  [`SLT_CNT_W-1:0] fwd_err;
    reg  [`SLT_CNT_W-1:0] crc_func;
    reg  [`SLT_CNT_W-1:0] crc_test;
    reg                   any_err;
    reg                   err_pend;
    reg                   low_phase;
    reg                   tclk_d;
    reg                   remote_d;

    // Bus address phase capture
    reg                   dp_write;
    reg  [7:0]            dp_index;
    wire                  ap_valid = hsel & hready & htrans[1];
    wire [7:0]            ap_index = word_index(haddr);

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Oscillator and back-channel bit timing
    wire osc_phase;
    wire osc_tick;
    slt_osc #(.RATE_KHZ(`SLT_OSC_KHZ), .CLK_KHZ(`SLT_CORE_KHZ)) u_osc (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clear    (pd_clear),
        .phase    (osc_phase),
        .tick     ()
    );
    slt_osc #(.RATE_KHZ(`SLT_BC_KBPS), .CLK_KHZ(`SLT_CORE_KHZ)) u_bc (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clear    (pd_clear),
        .phase    (),
        .tick     (bc_bit_tick)
    );

    // Test start and clock source
    wire test_en  = en_pin_s | ctrl[`SLT_CTRL_ENABLE];
    wire clk_sel  = sel_pin_s | ctrl[`SLT_CTRL_CLK_SEL];
    wire tclk     = clk_sel ? osc_phase : pclk_s;
    wire tclk_r   = tclk & ~tclk_d;
    wire tclk_f   = ~tclk & tclk_d;

    // Frame checking
    wire frame_err    = rx_frame_valid & (|rx_frame_bits);
    wire checking     = (state == ST_CHECK);
    wire check_start  = (state == ST_REQ) & (next_state == ST_CHECK);
    wire check_err    = checking & frame_err;
    wire remote_start = remote_self_test & ~remote_d;
    wire crc_event    = bc_frame_valid & bc_crc_error & remote_bc_lock;

    wire wr_ctrl = dp_write & (dp_index == `SLT_IDX_CTRL);
    wire crc_clr = wr_ctrl & hwdata[`SLT_CTRL_CRC_CLEAR];

    // Status word, one bit per field except the two-bit state
    wire       st_active = checking | (state == ST_REQ);
    wire [6:0] status_bits;
    assign status_bits[`SLT_STAT_LINK_DET] = remote_bc_lock;
    assign status_bits[`SLT_STAT_RX_LOCK]  = lock_s;
    assign status_bits[`SLT_STAT_PASS]     = pass_out;
    assign status_bits[`SLT_STAT_ACTIVE]   = st_active;
    assign status_bits[`SLT_STAT_ANY_ERR]  = any_err;
    assign status_bits[`SLT_STAT_STATE_LSB+1:`SLT_STAT_STATE_LSB] = state;

    // Sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (test_en)
                    next_state = ST_REQ;
            end
            ST_REQ: begin
                if (!test_en)
                    next_state = ST_IDLE;
                else if (remote_self_test && lock_s)
                    next_state = ST_CHECK;
            end
            ST_CHECK: begin
                if (!test_en)
                    next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (test_en)
                    next_state = ST_REQ;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else if (pd_clear) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Back-channel request changes only on bit boundaries, except when power-down clears it
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bc_self_test_request <= 1'b0;
            link_normal          <= 1'b1;
        end else if (pd_clear) begin
            bc_self_test_request <= 1'b0;
            link_normal          <= 1'b1;
        end else begin
            if (bc_bit_tick)
                bc_self_test_request <= test_en;
            link_normal <= (state == ST_IDLE) | (state == ST_HOLD);
        end
    end

    // Error pulse and verdict; pulse edges land within one core cycle
    // of the sampled test clock edges
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tclk_d    <= 1'b0;
            remote_d  <= 1'b0;
            err_pend  <= 1'b0;
            low_phase <= 1'b0;
            any_err   <= 1'b0;
            pass_out  <= `SLT_PASS_RESET;
        end else if (pd_clear) begin
            tclk_d    <= 1'b0;
            remote_d  <= 1'b0;
            err_pend  <= 1'b0;
            low_phase <= 1'b0;
            any_err   <= 1'b0;
            pass_out  <= `SLT_PASS_RESET;
        end else begin
            tclk_d   <= tclk;
            remote_d <= remote_self_test;
            if (check_start) begin
                any_err   <= 1'b0;
                err_pend  <= 1'b0;
                low_phase <= 1'b0;
                pass_out  <= 1'b1;
            end else if (checking) begin
                // Error wins over the clear of the pending flag
                if (check_err) begin
                    any_err  <= 1'b1;
                    err_pend <= 1'b1;
                end else if (tclk_r) begin
                    err_pend <= 1'b0;
                end
                if (tclk_r && err_pend)
                    low_phase <= 1'b1;
                else if (tclk_f)
                    low_phase <= 1'b0;
                if (!test_en)
                    pass_out <= ~(any_err | check_err);
                else
                    pass_out <= ~((tclk_r & err_pend) | (low_phase & ~tclk_f));
            end else begin
                low_phase <= 1'b0;
                err_pend  <= 1'b0;
            end
        end
    end

    // Counters saturate so a long run cannot wrap back to zero
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fwd_err  <= `SLT_CNT_RESET;
            crc_func <= `SLT_CNT_RESET;
            crc_test <= `SLT_CNT_RESET;
        end else if (pd_clear) begin
            fwd_err  <= `SLT_CNT_RESET;
            crc_func <= `SLT_CNT_RESET;
            crc_test <= `SLT_CNT_RESET;
        end else begin
            if (check_start)
                fwd_err <= `SLT_CNT_RESET;
            else if (check_err)
                fwd_err <= sat_inc(fwd_err);
            // A CRC error in the clearing cycle is still counted
            if (remote_start)
                crc_func <= crc_event ? 8'h01 : `SLT_CNT_RESET;
            else if (crc_event)
                crc_func <= sat_inc(crc_func);
            if (remote_start)
                crc_test <= crc_event ? 8'h01 : `SLT_CNT_RESET;
            else if (crc_event && remote_self_test)
                crc_test <= sat_inc(crc_test);
            else if (crc_clr)
                crc_test <= `SLT_CNT_RESET;
        end
    end

    // Bus slave: write in data phase, read data registered at address phase
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dp_write <= 1'b0;
            dp_index <= 8'h00;
            ctrl     <= `SLT_CTRL_RESET;
            hrdata   <= 32'h0000_0000;
        end else if (pd_clear) begin
            dp_write <= 1'b0;
            dp_index <= 8'h00;
            ctrl     <= `SLT_CTRL_RESET;
            hrdata   <= 32'h0000_0000;
        end else begin
            dp_write <= ap_valid & hwrite;
            dp_index <= ap_index;
            if (wr_ctrl)
                ctrl <= hwdata[1:0];
            if (ap_valid && !hwrite) begin
                case (ap_index)
                    `SLT_IDX_CTRL:     hrdata <= {30'h0000_0000, ctrl};
                    `SLT_IDX_STATUS:   hrdata <= {25'h000_0000, status_bits};
                    `SLT_IDX_FWD_ERR:  hrdata <= {24'h00_0000, fwd_err};
                    `SLT_IDX_CRC_FUNC: hrdata <= {24'h00_0000, crc_func};
                    `SLT_IDX_CRC_TEST: hrdata <= {24'h00_0000, crc_test};
                    default:           hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // slt_checker

// ==== hw/slt_defs.vh ====
// Constants for the serial link self-test checker.
// Included by bare name from the checker and its bench.
`ifndef SLT_DEFS_VH
`define SLT_DEFS_VH

// Register word indexes; byte address is four times the index
`define SLT_IDX_CTRL        8'h00
`define SLT_IDX_STATUS      8'h0C
`define SLT_IDX_FWD_ERR     8'h25
`define SLT_IDX_CRC_FUNC    8'h26
`define SLT_IDX_CRC_TEST    8'h27

// Control fields
`define SLT_CTRL_ENABLE     0
`define SLT_CTRL_CLK_SEL    1
`define SLT_CTRL_CRC_CLEAR  2
`define SLT_CTRL_RESET      2'h0

// Status fields
`define SLT_STAT_LINK_DET   0
`define SLT_STAT_RX_LOCK    1
`define SLT_STAT_PASS       2
`define SLT_STAT_ACTIVE     3
`define SLT_STAT_ANY_ERR    4
`define SLT_STAT_STATE_LSB  5

// Counter widths and reset values
`define SLT_CNT_W           8
`define SLT_CNT_RESET       8'h00
`define SLT_PASS_RESET      1'b0

// Rates in kHz
`define SLT_CORE_KHZ        125000
`define SLT_OSC_KHZ         33000
`define SLT_BC_KBPS         10000

// Recovered frame payload width
`define SLT_FRAME_W         35

`endif

// ==== hw/slt_osc.v ====
// Fractional rate generator: a phase level and a one-cycle rising tick.
// Assumes RATE_KHZ is below half of CLK_KHZ.
`timescale 1ns/1ps
module slt_osc #(
    parameter RATE_KHZ = 33000,
    parameter CLK_KHZ  = 125000
) (
    input  wire core_clk,
    input  wire resetn,
    input  wire clear,
    output wire phase,
    output wire tick
);
    localparam ACC_W    = 12;
    localparam STEP_INT = (RATE_KHZ * 4096) / CLK_KHZ;
    localparam [ACC_W-1:0] STEP = STEP_INT[ACC_W-1:0];

    reg  [ACC_W-1:0] acc;
    reg              phase_d;

    // Small jitter of one core cycle traded for no extra clock
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc     <= {ACC_W{1'b0}};
            phase_d <= 1'b0;
        end else if (clear) begin
            acc     <= {ACC_W{1'b0}};
            phase_d <= 1'b0;
        end else begin
            acc     <= acc + STEP;
            phase_d <= acc[ACC_W-1];
        end
    end

    assign phase = acc[ACC_W-1];
    assign tick  = acc[ACC_W-1] & ~phase_d;
endmodule // slt_osc

// ==== hw/slt_sync.v ====
// Two-flop level synchroniser for pins entering the core clock domain.
// Assumes inputs are quasi-static levels relative to core_clk.
`timescale 1ns/1ps
module slt_sync #(
    parameter W = 1
) (
    input  wire         core_clk,
    input  wire         resetn,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta;

    // First flop feeds only the second
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta     <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // slt_sync

// ==== sim/slt_checker_asserts.sv ====
// Port assertions for the serial link self-test checker.
// Assumes one core_clk domain; bound to slt_checker below.
`timescale 1ns/1ps
module slt_checker_asserts (
    input wire core_clk,
    input wire resetn,
    input wire hreadyout,
    input wire hresp,
    input wire self_test_enable_pin,
    input wire power_down_input,
    input wire rx_lock_pin,
    input wire remote_self_test,
    input wire bc_self_test_request,
    input wire bc_bit_tick,
    input wire pass_out,
    input wire lock_out,
    input wire link_normal
);
    reg  [3:0] pd_q;
    // Power-down clears after a sync delay; checks pause around it
    wire       quiet = power_down_input & (&pd_q);
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            pd_q <= 4'hf;
        else
            pd_q <= {pd_q[2:0], power_down_input};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn || !quiet);
    sequence s_gap;
        (!bc_bit_tick)[*8] ##1 (!bc_bit_tick)[*3];
    endsequence
    sequence s_check;
        remote_self_test && lock_out && bc_self_test_request && !link_normal;
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus stalled or not okay");
    AST_TICK_GAP: assert property (bc_bit_tick |=> s_gap)
        else $error("bit tick too early");
    AST_TICK_DUE: assert property (bc_bit_tick |-> ##[12:13] bc_bit_tick)
        else $error("bit tick late");
    AST_REQ_ON_TICK: assert property ($changed(bc_self_test_request) |-> bc_bit_tick || $past(bc_bit_tick))
        else $error("request moved off tick");
    AST_START: assert property ($rose(self_test_enable_pin) && link_normal |-> ##[2:5] !link_normal)
        else $error("test did not start");
    AST_STOP: assert property ($fell(self_test_enable_pin) && !link_normal |-> ##[2:5] link_normal)
        else $error("link not back to normal");
    AST_RESULT_HIGH: assert property ($rose(remote_self_test) ##0 s_check |-> ##[1:3] pass_out)
        else $error("result not raised at check entry");
    AST_ERR_PULSE: assert property ($fell(pass_out) ##0 s_check |-> ##[1:8] (pass_out || link_normal))
        else $error("error pulse too long");
    AST_HOLD: assert property (link_normal && $past(link_normal) && $past(link_normal, 2) |-> $stable(pass_out))
        else $error("held verdict moved");
    AST_LOCK_UP: assert property ($rose(rx_lock_pin) |-> ##[1:3] lock_out)
        else $error("lock output missed rise");
    AST_LOCK_DOWN: assert property ($fell(rx_lock_pin) |-> ##[1:3] !lock_out)
        else $error("lock output missed fall");
endmodule // slt_checker_asserts
bind slt_checker slt_checker_asserts u_slt_checker_asserts (
    .core_clk(core_clk), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
    .self_test_enable_pin(self_test_enable_pin), .power_down_input(power_down_input), .rx_lock_pin(rx_lock_pin),
    .remote_self_test(remote_self_test), .bc_self_test_request(bc_self_test_request), .bc_bit_tick(bc_bit_tick),
    .pass_out(pass_out), .lock_out(lock_out), .link_normal(link_normal));

// ==== sim/slt_checker_bench.sv ====
// Self-checking bench for the self-test checker with remote model.
// Assumes slt_defs.vh on the include path; zero-wait AHB-Lite slave.
`timescale 1ns/1ps
`include "slt_defs.vh"
module slt_checker_bench;
    reg         core_clk, resetn, hsel, hwrite, pclk_run, err_req, crc_bad;
    reg  [31:0] haddr, hwdata;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg         self_test_enable_pin, self_test_clock_select_pin, power_down_input, pixel_clk_pin, rx_lock_pin;
    wire        hreadyout, hresp, rx_frame_valid, remote_bc_lock, remote_self_test, bc_frame_valid, bc_crc_error;
    wire [31:0] hrdata;
    wire [35:1] rx_frame_bits;
    wire        bc_self_test_request, bc_bit_tick, pass_out, lock_out, link_normal;
    reg         pass_q;
    integer     bad_count = 0, checks_done = 0, falls = 0, crc_seen = 0, f0, c0, b_cnt;
    slt_checker u_slt_checker (
        .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .self_test_enable_pin(self_test_enable_pin), .self_test_clock_select_pin(self_test_clock_select_pin),
        .power_down_input(power_down_input), .pixel_clk_pin(pixel_clk_pin), .rx_lock_pin(rx_lock_pin),
        .rx_frame_valid(rx_frame_valid), .rx_frame_bits(rx_frame_bits), .remote_bc_lock(remote_bc_lock),
        .remote_self_test(remote_self_test), .bc_frame_valid(bc_frame_valid), .bc_crc_error(bc_crc_error),
        .bc_self_test_request(bc_self_test_request), .bc_bit_tick(bc_bit_tick), .pass_out(pass_out),
        .lock_out(lock_out), .link_normal(link_normal));
    slt_remote_model u_slt_remote_model (
        .core_clk(core_clk), .resetn(resetn), .bc_self_test_request(bc_self_test_request),
        .bc_bit_tick(bc_bit_tick), .err_req(err_req), .crc_bad(crc_bad), .rx_frame_valid(rx_frame_valid),
        .rx_frame_bits(rx_frame_bits), .remote_bc_lock(remote_bc_lock), .remote_self_test(remote_self_test),
        .bc_frame_valid(bc_frame_valid), .bc_crc_error(bc_crc_error));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Pixel clock stands still outside test runs
    initial begin
        pixel_clk_pin = 1'b0;
        #3;
        forever #32 if (pclk_run) pixel_clk_pin = ~pixel_clk_pin;
    end
    always @(posedge core_clk) begin
        pass_q <= pass_out;
        if (pass_q && !pass_out && !link_normal)
            falls <= falls + 1;
        if (bc_frame_valid && bc_crc_error && remote_bc_lock)
            crc_seen <= crc_seen + 1;
    end
    // Expected status after a stopped run: held state, lock and link detect up
    function [31:0] status_exp(input integer n);
        status_exp = {25'h0, 2'h3, n != 0, 1'b0, n == 0, 2'b11};
    endfunction
    task close_out;
        begin
            if (bad_count == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task bus(input [7:0] idx, input w, input [31:0] d, output [31:0] r);
        begin
            @(posedge core_clk);
            hsel <= 1'b1;
            haddr <= {22'h0, idx, 2'b00};
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge core_clk);
            while (hreadyout !== 1'b1) @(posedge core_clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge core_clk);
            while (hreadyout !== 1'b1) @(posedge core_clk);
            r = hrdata;
        end
    endtask
    task rd(input [7:0] idx, input [31:0] e);
        reg [31:0] r;
        begin
            bus(idx, 1'b0, 32'h0, r);
            chk(r, e);
        end
    endtask
    task wr(input [7:0] idx, input [31:0] d);
        reg [31:0] r;
        begin
            bus(idx, 1'b1, d, r);
        end
    endtask
    task crc_win;
        begin
            crc_bad <= 1'b1;
            repeat (32 + $urandom % 64) @(posedge core_clk);
            crc_bad <= 1'b0;
            repeat (20) @(posedge core_clk);
        end
    endtask
    task run_test(input by_reg, input integer n);
        integer i;
        reg     cs;
        begin
            cs = $urandom % 2;
            pclk_run = 1'b1;
            if (by_reg)
                wr(`SLT_IDX_CTRL, {30'h0, cs, 1'b1});
            else begin
                self_test_clock_select_pin <= cs;
                self_test_enable_pin <= 1'b1;
            end
            repeat (600) if (pass_out !== 1'b1) @(posedge core_clk);
            chk(pass_out, 1);
            chk(lock_out, 1);
            f0 = falls;
            for (i = 0; i < n; i = i + 1) begin
                err_req <= 1'b1;
                @(posedge core_clk);
                err_req <= 1'b0;
                repeat (40 + $urandom % 16) @(posedge core_clk);
            end
            c0 = crc_seen;
            crc_win;
            b_cnt = crc_seen - c0;
            rd(`SLT_IDX_CRC_FUNC, b_cnt);
            rd(`SLT_IDX_CRC_TEST, b_cnt);
            chk(falls - f0, n);
            if (by_reg)
                wr(`SLT_IDX_CTRL, 32'h0);
            else
                self_test_enable_pin <= 1'b0;
            repeat (200) if (link_normal !== 1'b1) @(posedge core_clk);
            pclk_run = 1'b0;
            chk(link_normal, 1);
            chk(pass_out, n == 0);
            rd(`SLT_IDX_FWD_ERR, n);
            rd(`SLT_IDX_STATUS, status_exp(n));
            repeat (40) @(posedge core_clk);
            chk(pass_out, n == 0);
        end
    endtask
    initial begin
        {resetn, hsel, hwrite, pclk_run, err_req, crc_bad, self_test_enable_pin} = 7'h0;
        {self_test_clock_select_pin, rx_lock_pin, htrans, haddr, hwdata} = 68'h0;
        power_down_input = 1'b1;
        hsize = 3'h2;
        void'($urandom(32'hc5cb));
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        rd(`SLT_IDX_CTRL, 32'h0);
        rd(`SLT_IDX_FWD_ERR, 32'h0);
        rd(8'h30, 32'h0);
        chk(pass_out, 0);
        rx_lock_pin <= 1'b1;
        crc_win;
        rd(`SLT_IDX_CRC_FUNC, crc_seen);
        rd(`SLT_IDX_CRC_TEST, 32'h0);
        run_test(1, 1 + $urandom % 4);
        c0 = crc_seen;
        crc_win;
        rd(`SLT_IDX_CRC_FUNC, b_cnt + crc_seen - c0);
        rd(`SLT_IDX_CRC_TEST, b_cnt);
        wr(`SLT_IDX_CTRL, 32'h4);
        rd(`SLT_IDX_CRC_TEST, 32'h0);
        run_test(0, 0);
        rx_lock_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(lock_out, 0);
        power_down_input <= 1'b0;
        repeat (8) @(posedge core_clk);
        power_down_input <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(pass_out, 0);
        rd(`SLT_IDX_CRC_TEST, 32'h0);
        close_out;
    end
    initial begin
        #200000;
        bad_count = bad_count + 1;
        close_out;
    end
endmodule // slt_checker_bench

// ==== sim/slt_remote_model.sv ====
// Remote serializer model: forward frames, back-channel CRC, test handshake.
// Assumes all strobes in core_clk; request is read on bc_bit_tick only.
`timescale 1ns/1ps
module slt_remote_model (
    input  wire        core_clk,
    input  wire        resetn,
    input  wire        bc_self_test_request,
    input  wire        bc_bit_tick,
    input  wire        err_req,
    input  wire        crc_bad,
    output reg         rx_frame_valid,
    output reg  [35:1] rx_frame_bits,
    output reg         remote_bc_lock,
    output reg         remote_self_test,
    output reg         bc_frame_valid,
    output reg         bc_crc_error
);
    reg [3:0] ph;
    reg       err_pend;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {ph, err_pend, rx_frame_valid, remote_bc_lock} <= 7'h0;
            {remote_self_test, bc_frame_valid, bc_crc_error} <= 3'h0;
            rx_frame_bits <= 35'h0;
        end else begin
            ph <= ph + 4'h1;
            remote_bc_lock <= 1'b1;
            // Slow answer: request only seen at bit rate
            if (bc_bit_tick)
                remote_self_test <= bc_self_test_request;
            rx_frame_valid <= (ph[2:0] == 3'h0);
            bc_frame_valid <= (ph == 4'h8);
            bc_crc_error <= crc_bad && (ph == 4'h8);
            if (ph[2:0] != 3'h0)
                rx_frame_bits <= ~rx_frame_bits;
            else if (!remote_self_test)
                rx_frame_bits <= {$urandom, 3'h5};
            else
                rx_frame_bits <= err_pend ? 35'h1 << ($urandom % 35) : 35'h0;
            if (ph[2:0] == 3'h0)
                err_pend <= err_req;
            else if (err_req)
                err_pend <= 1'b1;
        end
    end
endmodule // slt_remote_model
